// file: src/dcce_pkg.sv
package dcce_pkg;
   // -----------------------------------------------------------------
   // Widths and counts
   // -----------------------------------------------------------------
   localparam int CODE_W   = 14;
   localparam int NCH      = 8;
   localparam int CH_W     = 3;
   localparam int GRP_SIZE = 4;
   localparam int QPTR_W   = 4;
   localparam int PROD_W   = 29;
   localparam int SUM_W    = 16;

   // -----------------------------------------------------------------
   // Register map (byte addresses; channel n at base + 4*n)
   // -----------------------------------------------------------------
   localparam logic [11:0] ADDR_INPUT_BASE = 12'h000;
   localparam logic [11:0] ADDR_GAIN_BASE  = 12'h020;
   localparam logic [11:0] ADDR_ZERO_BASE  = 12'h040;
   localparam logic [11:0] ADDR_DATA_BASE  = 12'h060;
   localparam logic [11:0] ADDR_CONFIG     = 12'h080;
   localparam logic [11:0] ADDR_STATUS     = 12'h084;
   localparam logic [11:0] ADDR_LOAD       = 12'h088;
   localparam logic [11:0] ADDR_BANK_MASK  = 12'h0e0;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int CFG_ENABLE_BIT  = 0;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_PEND_LSB   = 8;
   localparam int LOAD_GRPA_BIT   = 0;
   localparam int LOAD_GRPB_BIT   = 1;

   localparam logic [13:0] GAIN_RESET  = 14'h2000;
   localparam logic [13:0] ZERO_RESET  = 14'h0000;
   localparam logic [13:0] INPUT_RESET = 14'h0000;
   localparam logic [13:0] GAIN_BIAS   = 14'h2000;
   localparam logic [13:0] CODE_MAX    = 14'h3fff;
   localparam int          GAIN_SHIFT  = 14;

   typedef enum logic [1:0] {
      DCCE_IDLE = 2'b00,
      DCCE_MUL  = 2'b01,
      DCCE_ADD  = 2'b10
   } dcce_state_t;
endpackage

// file: src/dcce_core.sv
`timescale 1ns/1ps
module dcce_core (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [11:0]                     paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   output logic      [dcce_pkg::NCH*dcce_pkg::CODE_W-1:0] latch_code,
   output logic      [1:0]                      latch_load_done
);
   import dcce_pkg::*;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [CODE_W-1:0] input_reg [NCH];
   logic [CODE_W-1:0] gain_reg  [NCH];
   logic [CODE_W-1:0] zero_reg  [NCH];
   logic [CODE_W-1:0] data_reg  [NCH];
   logic [CODE_W-1:0] latch_reg [NCH];
   logic              correction_engine_enable;

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------
   wire               access     = psel && penable && !pready;
   wire               wr_en      = access && pwrite;
   wire [CH_W-1:0]    a_ch       = paddr[CH_W+1:2];
   wire [11:0]        a_base     = {paddr[11:5], 5'h00};
   wire               a_aligned  = (paddr[1:0] == 2'b00);
   wire               hit_input  = a_aligned && (a_base == ADDR_INPUT_BASE);
   wire               hit_gain   = a_aligned && (a_base == ADDR_GAIN_BASE);
   wire               hit_zero   = a_aligned && (a_base == ADDR_ZERO_BASE);
   wire               hit_data   = a_aligned && (a_base == ADDR_DATA_BASE);
   wire               hit_config = paddr == ADDR_CONFIG;
   wire               hit_status = paddr == ADDR_STATUS;
   wire               hit_load   = paddr == ADDR_LOAD;
   wire               hit_any    = hit_input | hit_gain | hit_zero | hit_data |
                                   hit_config | hit_status | hit_load;
   wire               wr_input   = wr_en && hit_input;
   wire               wr_gain    = wr_en && hit_gain;
   wire               wr_zero    = wr_en && hit_zero;
   wire [CODE_W-1:0]  wcode      = pwdata[CODE_W-1:0];

   // -----------------------------------------------------------------
   // Request queue: pending bit per channel plus an arrival-order FIFO
   // -----------------------------------------------------------------
   // A channel already waiting is not queued twice; its later write is
   // picked up because the engine reads the registers in its MUL and ADD steps, after it starts.
   logic [NCH-1:0]    pending;
   logic [CH_W-1:0]   q_mem [NCH];
   logic [QPTR_W-1:0] q_wr;
   logic [QPTR_W-1:0] q_rd;
   dcce_state_t       state;
   logic [CH_W-1:0]   eng_ch;
   logic [PROD_W-1:0] product;

   wire               req_new   = (wr_input || wr_gain || wr_zero) &&
                                  correction_engine_enable && !pending[a_ch];
   wire               q_empty   = (q_wr == q_rd);
   wire               eng_start = (state == DCCE_IDLE) && !q_empty;
   wire [CH_W-1:0]    head_ch   = q_mem[q_rd[CH_W-1:0]];

   // -----------------------------------------------------------------
   // Shared arithmetic unit
   // -----------------------------------------------------------------
   // Multiply and add are split over two cycles to keep one short
   // critical path per stage; one unit serves all channels.
   wire [CODE_W:0]    gain_coef = {1'b0, gain_reg[eng_ch]} + {1'b0, GAIN_BIAS};
   wire [PROD_W-1:0]  next_product = PROD_W'({14'h0000, input_reg[eng_ch]} *
                                             {14'h0000, gain_coef});
   wire [SUM_W-1:0]   scaled    = SUM_W'(product >> GAIN_SHIFT);
   wire [SUM_W-1:0]   zero_ext  = {{(SUM_W-CODE_W){zero_reg[eng_ch][CODE_W-1]}},
                                   zero_reg[eng_ch]};
   wire [SUM_W:0]     sum_s     = {1'b0, scaled} + {zero_ext[SUM_W-1], zero_ext};
   wire               sum_neg   = sum_s[SUM_W];
   wire               sum_ovf   = !sum_neg && (sum_s[SUM_W-1:CODE_W] != 2'b00);
   wire [CODE_W-1:0]  clamped   = sum_neg ? {CODE_W{1'b0}} :
                                  sum_ovf ? CODE_MAX : sum_s[CODE_W-1:0];

   // -----------------------------------------------------------------
   // Engine state machine
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= DCCE_IDLE;
         eng_ch  <= '0;
         product <= '0;
      end else begin
         unique case (state)
            DCCE_IDLE: begin
               if (eng_start) begin
                  eng_ch <= head_ch;
                  state  <= DCCE_MUL;
               end
            end
            DCCE_MUL: begin
               product <= next_product;
               state   <= DCCE_ADD;
            end
            DCCE_ADD: begin
               state <= DCCE_IDLE;
            end
            default: state <= DCCE_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_wr <= '0;
         q_rd <= '0;
      end else begin
         if (req_new)
            q_wr <= q_wr + 1'b1;
         if (eng_start)
            q_rd <= q_rd + 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (req_new)
         q_mem[q_wr[CH_W-1:0]] <= a_ch;
   end

   // -----------------------------------------------------------------
   // Per-channel registers
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         wire sel       = (a_ch == CH_W'(g));
         wire eng_done  = (state == DCCE_ADD) && (eng_ch == CH_W'(g));
         wire set_pend  = req_new && sel;
         wire clr_pend  = eng_start && (head_ch == CH_W'(g));
         wire grp_b     = (g >= GRP_SIZE);
         wire grp_load  = wr_en && hit_load &&
                          pwdata[grp_b ? LOAD_GRPB_BIT : LOAD_GRPA_BIT];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               input_reg[g] <= INPUT_RESET;
               gain_reg[g]  <= GAIN_RESET;
               zero_reg[g]  <= ZERO_RESET;
               data_reg[g]  <= INPUT_RESET;
               latch_reg[g] <= INPUT_RESET;
               pending[g]   <= 1'b0;
            end else begin
               if (wr_input && sel)
                  input_reg[g] <= wcode;
               if (wr_gain && sel)
                  gain_reg[g] <= wcode;
               if (wr_zero && sel)
                  zero_reg[g] <= wcode;
               if (eng_done)
                  data_reg[g] <= clamped;
               else if (wr_input && sel && !correction_engine_enable)
                  data_reg[g] <= wcode;
               if (grp_load)
                  latch_reg[g] <= data_reg[g];
               // Set wins over the start that clears
               if (set_pend)
                  pending[g] <= 1'b1;
               else if (clr_pend)
                  pending[g] <= 1'b0;
            end
         end
         assign latch_code[g*CODE_W +: CODE_W] = latch_reg[g];
      end
   endgenerate

   // -----------------------------------------------------------------
   // Config, load pulse and APB answer
   // -----------------------------------------------------------------
   wire busy = (state != DCCE_IDLE) || !q_empty;
   wire [31:0] rd_mux =
      hit_input  ? {18'h00000, input_reg[a_ch]} :
      hit_gain   ? {18'h00000, gain_reg[a_ch]}  :
      hit_zero   ? {18'h00000, zero_reg[a_ch]}  :
      hit_data   ? {18'h00000, data_reg[a_ch]}  :
      hit_config ? 32'(correction_engine_enable) << CFG_ENABLE_BIT :
      hit_status ? (32'(pending) << STAT_PEND_LSB) | (32'(busy) << STAT_BUSY_BIT) :
      32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         correction_engine_enable <= 1'b0;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= '0;
         latch_load_done <= 2'b00;
      end else begin
         if (wr_en && hit_config)
            correction_engine_enable <= pwdata[CFG_ENABLE_BIT];
         pready          <= access;
         pslverr         <= access && !hit_any;
         prdata          <= (access && !pwrite) ? rd_mux : 32'h00000000;
         latch_load_done <= (wr_en && hit_load) ?
                            {pwdata[LOAD_GRPB_BIT], pwdata[LOAD_GRPA_BIT]} : 2'b00;
      end
   end
endmodule

// file: test/dcce_core_sva.sv
`timescale 1ns/1ps
module dcce_core_sva (
   input wire logic                                      pclk,
   input wire logic                                      presetn,
   input wire logic                                      psel,
   input wire logic                                      penable,
   input wire logic                                      pwrite,
   input wire logic [11:0]                               paddr,
   input wire logic [31:0]                               pwdata,
   input wire logic [31:0]                               prdata,
   input wire logic                                      pready,
   input wire logic                                      pslverr,
   input wire logic [dcce_pkg::NCH*dcce_pkg::CODE_W-1:0] latch_code,
   input wire logic [1:0]                                latch_load_done
);
   import dcce_pkg::*;
   // ----
   // Bus and latch checks
   // ----
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait:
      assert property (psel && penable && !pready |=> pready) else $error("no answer");
   a_ready_pulse:
      assert property (pready |=> !pready) else $error("ready too long");
   a_ready_cause:
      assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   a_err_with_ready:
      assert property (pslverr |-> pready) else $error("stray error");
   a_rdata_idle:
      assert property (!pready |-> prdata == 32'h0) else $error("data outside answer");
   a_rdata_upper:
      assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
   a_load_pulse:
      assert property (latch_load_done != 2'h0 |=> latch_load_done == 2'h0)
         else $error("load flag too long");
   a_latch_cause:
      assert property ($changed(latch_code) |-> $past(pwrite && psel, 1) || $past(pwrite && psel, 2))
         else $error("latch moved without write");
endmodule
bind dcce_core dcce_core_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .latch_code(latch_code),
   .latch_load_done(latch_load_done));

// file: test/dcce_host.sv
`timescale 1ns/1ps
module dcce_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   // ----
   // Register read/write master; released address and data show inverted values
   // ----
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// file: test/dcce_core_tb_top.sv
`timescale 1ns/1ps
module dcce_core_tb_top;
   import dcce_pkg::*;
   logic                  pclk = 0, presetn = 0, en = 0;
   logic                  psel, penable, pwrite, pready, pslverr;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata;
   logic [NCH*CODE_W-1:0] latch_code;
   logic [1:0]            latch_load_done;
   logic [34:0]           exp_q[$];
   logic [13:0]           inp[NCH], gn[NCH], zr[NCH], dat[NCH], lat[NCH];
   int                    fails = 0, comparisons = 0, cycles = 0, seed = 55;
   always #20 pclk = ~pclk;
   dcce_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .latch_code(latch_code), .latch_load_done(latch_load_done));
   dcce_host i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // ----
   // Helpers
   // ----
   task automatic check(input logic [34:0] seen, input logic [34:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("ERROR %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [13:0] corr(input logic [13:0] c, g, z);
      int s;
      s = ((int'(c) * (int'(g) + 8192)) >>> 14) + int'($signed(z));
      return (s < 0) ? 14'h0 : (s > 16383) ? CODE_MAX : 14'(s);
   endfunction
   task automatic wr(input logic [11:0] a, input logic [13:0] d, input logic err = 0);
      // Load pulse stands with the answer of a load write, else stays low
      exp_q.push_back({((a == ADDR_LOAD) ? d[1:0] : 2'b00), err, 32'h0});
      i_host.xfer(1'b1, a, {18'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [13:0] d, input logic err = 0);
      exp_q.push_back({2'b00, err, 18'h0, d});
      i_host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic put(input int k, input int ch, input logic [13:0] v);
      wr((k == 0 ? ADDR_INPUT_BASE : k == 1 ? ADDR_GAIN_BASE : ADDR_ZERO_BASE) + 12'(4 * ch), v);
      if (k == 0) inp[ch] = v;
      else if (k == 1) gn[ch] = v;
      else zr[ch] = v;
      if (en) dat[ch] = corr(inp[ch], gn[ch], zr[ch]);
      else if (k == 0) dat[ch] = v;
   endtask
   task automatic rdall(input string name);
      repeat (8) @(posedge pclk);
      for (int ch = 0; ch < NCH; ch++) begin
         rd(ADDR_GAIN_BASE + 12'(4 * ch), gn[ch]);
         rd(ADDR_ZERO_BASE + 12'(4 * ch), zr[ch]);
         rd(ADDR_INPUT_BASE + 12'(4 * ch), inp[ch]);
         rd(ADDR_DATA_BASE + 12'(4 * ch), dat[ch]);
      end
      rd(ADDR_STATUS, 14'h0);
      rd(ADDR_CONFIG, {13'h0, en});
      rd(ADDR_LOAD, 14'h0);
      $display("test %s done", name);
   endtask
   // ----
   // Answer monitor and hang guard
   // ----
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         fails++;
         finish_test();
      end
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) check(35'h1, 35'h0);
         else check({latch_load_done, pslverr, prdata}, exp_q.pop_front());
      end
   end
   // ----
   // Scenarios
   // ----
   initial begin
      for (int ch = 0; ch < NCH; ch++) begin
         {inp[ch], zr[ch], dat[ch], lat[ch]} = '0;
         gn[ch] = GAIN_RESET;
      end
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdall("reset");
      for (int ch = 0; ch < NCH; ch++)
         for (int k = 0; k < 3; k++) put(k, ch, 14'($random(seed)));
      rdall("bypass");
      wr(ADDR_CONFIG, 14'h1);
      en = 1'b1;
      repeat (24) put({$random(seed)} % 3, {$random(seed)} % NCH, 14'($random(seed)));
      rdall("random");
      // Extremes of gain and zero; ch0 and ch3 overflow, ch1 underflows
      put(1, 0, 14'h3fff); put(2, 0, 14'h1fff); put(0, 0, 14'h3fff);
      put(1, 1, 14'h0000); put(2, 1, 14'h2000); put(0, 1, 14'h0000);
      put(1, 2, 14'h0000); put(2, 2, 14'h0000); put(0, 2, 14'h3fff);
      put(1, 3, 14'h3fff); put(2, 3, 14'h0000); put(0, 3, 14'h3fff);
      for (int ch = 4; ch < NCH; ch++) put(0, ch, 14'($random(seed)));
      rdall("extremes");
      for (int g = 0; g < 2; g++) begin
         wr(ADDR_LOAD, 14'(1 << g));
         repeat (3) @(posedge pclk);
         for (int ch = 0; ch < NCH; ch++) begin
            if (ch / GRP_SIZE == g) lat[ch] = dat[ch];
            check({21'h0, latch_code[ch*CODE_W +: CODE_W]}, {21'h0, lat[ch]});
         end
      end
      rd(12'h0fc, 14'h0, 1'b1);
      wr(12'h0fc, 14'h5, 1'b1);
      rdall("load");
      finish_test();
   end
endmodule
